// [hw/sbdt_timers.sv]
// Two six-bit down timers with re-load and converter gating, AXI4-Lite slave
//
// The AXI4-Lite slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module sbdt_timers
    import sbdt_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        wdt_rst,
    input  wire logic        ext_count_clock,
    input  wire logic        halted,
    input  wire logic [5:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [5:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic             irq,
    output logic             wake_up,
    output logic             conv_count_enable,
    output logic             timer_a_underflow,
    output logic             timer_b_underflow
);

    // Selects one predivider tap, or the external source, by code
    function automatic logic tap_pick(input logic [2:0] sel,
                                      input logic [SBDT_PREDIV_W-1:0] ticks,
                                      input logic ext_tick);
        unique case (sel)
            SBDT_SEL_TAP9:  tap_pick = ticks[8];
            SBDT_SEL_TAP3:  tap_pick = ticks[2];
            SBDT_SEL_TAP15: tap_pick = ticks[14];
            SBDT_SEL_EXT:   tap_pick = ext_tick;
            SBDT_SEL_TAP5:  tap_pick = ticks[4];
            SBDT_SEL_TAP7:  tap_pick = ticks[6];
            SBDT_SEL_TAP11: tap_pick = ticks[10];
            SBDT_SEL_TAP13: tap_pick = ticks[12];
        endcase
    endfunction

    // Forms the nine-bit load word from a bus write
    function automatic logic [8:0] load_word(input logic [31:0] d);
        load_word = d[SBDT_REG_FORM_BIT] ? {1'b0, d[7:0]} : d[8:0];
    endfunction

    // Predivider stand-in: free binary counter, stage n toggles every 2^n mclk
    logic [SBDT_PREDIV_W-1:0] prediv_reg;
    logic [SBDT_PREDIV_W-1:0] prediv_next;
    logic [SBDT_PREDIV_W-1:0] stage_tick;
    assign prediv_next = prediv_reg + 15'h0001;
    // Stage n completes a period when its low n+1 bits roll over
    genvar gi;
    generate
        for (gi = 0; gi < SBDT_PREDIV_W; gi++) begin : g_tick
            assign stage_tick[gi] = &prediv_reg[gi:0];
        end
    endgenerate
    always_ff @(posedge mclk) begin
        if (rst) begin
            prediv_reg <= '0;
        end else begin
            prediv_reg <= prediv_next;
        end
    end

    // External source rising edge, one tick per period
    logic ext_sync1_reg;
    logic ext_sync2_reg;
    logic ext_prev_reg;
    logic ext_tick;
    assign ext_tick = ext_sync2_reg & ~ext_prev_reg;
    always_ff @(posedge mclk) begin
        ext_sync1_reg <= ext_count_clock;
        ext_sync2_reg <= ext_sync1_reg;
        ext_prev_reg  <= ext_sync2_reg;
    end

    // AXI4-Lite write side: address and data captured in either order
    logic        aw_held_reg;
    logic        w_held_reg;
    logic [5:0]  awaddr_reg;
    logic [31:0] wdata_reg;
    logic        bvalid_reg;
    logic [1:0]  bresp_reg;
    logic        wr_fire;
    logic        wr_hit;
    assign s_axi_awready = ~aw_held_reg & ~bvalid_reg;
    assign s_axi_wready  = ~w_held_reg & ~bvalid_reg;
    assign s_axi_bvalid  = bvalid_reg;
    assign s_axi_bresp   = bresp_reg;
    assign wr_fire = aw_held_reg & w_held_reg & ~bvalid_reg;
    assign wr_hit  = (awaddr_reg == SBDT_OFS_TA_LOAD) | (awaddr_reg == SBDT_OFS_TB_LOAD)
                   | (awaddr_reg == SBDT_OFS_FLAGS) | (awaddr_reg == SBDT_OFS_ENABLES)
                   | (awaddr_reg == SBDT_OFS_CLEAR);
    // Partial strobes are treated as full words; registers fit in the low lanes
    logic wr_ok;
    logic s_axi_wstrb_any_reg;
    assign wr_ok = wr_fire & wr_hit & s_axi_wstrb_any_reg;

    always_ff @(posedge mclk) begin
        if (rst) begin
            aw_held_reg <= 1'b0;
            w_held_reg  <= 1'b0;
            awaddr_reg  <= '0;
            wdata_reg   <= '0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= SBDT_RESP_OKAY;
            s_axi_wstrb_any_reg <= 1'b0;
        end else begin
            if (s_axi_awvalid & s_axi_awready) begin
                aw_held_reg <= 1'b1;
                awaddr_reg  <= {s_axi_awaddr[5:2], 2'h0};
            end
            if (s_axi_wvalid & s_axi_wready) begin
                w_held_reg <= 1'b1;
                wdata_reg  <= s_axi_wdata;
                s_axi_wstrb_any_reg <= |s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_held_reg <= 1'b0;
                w_held_reg  <= 1'b0;
                bvalid_reg  <= 1'b1;
                bresp_reg   <= wr_hit ? SBDT_RESP_OKAY : SBDT_RESP_SLVERR;
            end else if (bvalid_reg & s_axi_bready) begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    // Write strobes into the timer logic
    logic wr_ta_load;
    logic wr_tb_load;
    logic wr_flags;
    logic wr_enables;
    logic wr_clear;
    assign wr_ta_load = wr_ok & (awaddr_reg == SBDT_OFS_TA_LOAD);
    assign wr_tb_load = wr_ok & (awaddr_reg == SBDT_OFS_TB_LOAD);
    assign wr_flags   = wr_ok & (awaddr_reg == SBDT_OFS_FLAGS);
    assign wr_enables = wr_ok & (awaddr_reg == SBDT_OFS_ENABLES);
    assign wr_clear   = wr_ok & (awaddr_reg == SBDT_OFS_CLEAR);

    logic [8:0] ta_word;
    logic [8:0] tb_word;
    assign ta_word = load_word(wdata_reg);
    assign tb_word = load_word(wdata_reg);

    // Timer state
    logic [5:0] ta_cnt_reg;
    logic [5:0] tb_cnt_reg;
    logic [2:0] ta_sel_reg;
    logic [2:0] tb_sel_reg;
    logic       ta_run_reg;
    logic       tb_run_reg;
    logic       ta_reload_reg;
    logic       tb_reload_reg;
    logic       gate_extend_flag;
    logic       conv_mode_reg;
    logic       conv_en_reg;
    logic       timer_a_wake_request;
    logic       timer_b_wake_request;
    logic [3:0] enables_reg;
    logic       ta_ufl_reg;
    logic       tb_ufl_reg;

    // Count ticks and underflows
    logic ta_tick;
    logic tb_tick;
    logic ta_uf;
    logic tb_uf;
    assign ta_tick = ta_run_reg & tap_pick(ta_sel_reg, stage_tick, ext_tick);
    assign tb_tick = tb_run_reg & tap_pick(tb_sel_reg, stage_tick, ext_tick);
    assign ta_uf = ta_tick & (ta_cnt_reg == 6'h00);
    assign tb_uf = tb_tick & (tb_cnt_reg == 6'h00);

    // A timer that has underflowed, with reload now off, stops at once; a load restarts it
    logic ta_stop_now;
    logic tb_stop_now;
    assign ta_stop_now = wr_flags & ~wdata_reg[SBDT_FLG_TA_RELOAD] & ta_ufl_reg;
    assign tb_stop_now = wr_flags & ~wdata_reg[SBDT_FLG_TB_RELOAD] & tb_ufl_reg;

    // Clock selections: power-on reset only, watchdog reset keeps them
    always_ff @(posedge mclk) begin
        if (rst) begin
            ta_sel_reg <= SBDT_TA_SEL_RST;
            tb_sel_reg <= SBDT_TB_SEL_RST;
        end else begin
            if (wr_ta_load) ta_sel_reg <= ta_word[SBDT_SEL_HI:SBDT_SEL_LO];
            if (wr_tb_load) tb_sel_reg <= tb_word[SBDT_SEL_HI:SBDT_SEL_LO];
        end
    end

    // Timer a counter; a load aligns no prescale, so fraction error applies
    always_ff @(posedge mclk) begin
        if (rst | wdt_rst) begin
            ta_cnt_reg <= SBDT_CNT_RST;
            ta_run_reg <= 1'b0;
            ta_ufl_reg <= 1'b0;
        end else if (wr_ta_load) begin
            ta_cnt_reg <= ta_word[SBDT_CNT_HI:0];
            ta_run_reg <= 1'b1;
            ta_ufl_reg <= 1'b0;
        end else if (ta_stop_now) begin
            ta_run_reg <= 1'b0;
        end else if (ta_tick) begin
            ta_cnt_reg <= ta_cnt_reg - 6'h01;
            if (ta_uf) begin
                ta_run_reg <= ta_reload_reg;
                ta_ufl_reg <= 1'b1;
            end
        end else if (wr_flags & wdata_reg[SBDT_FLG_TA_RELOAD] & ~ta_reload_reg) begin
            ta_run_reg <= 1'b1;
        end
    end

    // Timer b counter; converter mode starts on a prescale edge for an exact gate
    logic tb_arm_reg;
    always_ff @(posedge mclk) begin
        if (rst | wdt_rst) begin
            tb_cnt_reg <= SBDT_CNT_RST;
            tb_run_reg <= 1'b0;
            tb_ufl_reg <= 1'b0;
            tb_arm_reg <= 1'b0;
        end else if (wr_tb_load) begin
            tb_cnt_reg <= tb_word[SBDT_CNT_HI:0];
            tb_run_reg <= ~conv_mode_reg;
            tb_arm_reg <= conv_mode_reg;
            tb_ufl_reg <= 1'b0;
        end else if (tb_arm_reg & tap_pick(tb_sel_reg, stage_tick, ext_tick)) begin
            tb_run_reg <= 1'b1;
            tb_arm_reg <= 1'b0;
        end else if (tb_stop_now) begin
            tb_run_reg <= 1'b0;
        end else if (tb_tick) begin
            tb_cnt_reg <= tb_cnt_reg - 6'h01;
            if (tb_uf) begin
                tb_run_reg <= tb_reload_reg;
                tb_ufl_reg <= 1'b1;
            end
        end else if (wr_flags & wdata_reg[SBDT_FLG_TB_RELOAD] & ~tb_reload_reg) begin
            tb_run_reg <= 1'b1;
        end
    end

    // Flags and enables
    always_ff @(posedge mclk) begin
        if (rst | wdt_rst) begin
            ta_reload_reg    <= 1'b0;
            tb_reload_reg    <= 1'b0;
            gate_extend_flag <= 1'b0;
            conv_mode_reg    <= 1'b0;
            enables_reg      <= 4'h0;
        end else begin
            if (wr_flags) begin
                ta_reload_reg    <= wdata_reg[SBDT_FLG_TA_RELOAD];
                tb_reload_reg    <= wdata_reg[SBDT_FLG_TB_RELOAD];
                gate_extend_flag <= wdata_reg[SBDT_FLG_GATE_EXT];
                conv_mode_reg    <= wdata_reg[SBDT_FLG_CONV_MODE];
            end
            if (wr_enables) enables_reg <= wdata_reg[3:0];
        end
    end

    // Converter gate: set at start, cleared at underflow unless extended
    always_ff @(posedge mclk) begin
        if (rst | wdt_rst) begin
            conv_en_reg <= 1'b0;
        end else if (conv_mode_reg & tb_arm_reg & tap_pick(tb_sel_reg, stage_tick, ext_tick)) begin
            conv_en_reg <= 1'b1;
        end else if (tb_uf & ~gate_extend_flag) begin
            conv_en_reg <= 1'b0;
        end
    end

    // Wake requests: an underflow wins over a same-cycle clear
    logic ta_ufl_pulse_reg;
    logic tb_ufl_pulse_reg;
    always_ff @(posedge mclk) begin
        if (rst | wdt_rst) begin
            timer_a_wake_request <= 1'b0;
            timer_b_wake_request <= 1'b0;
            ta_ufl_pulse_reg     <= 1'b0;
            tb_ufl_pulse_reg     <= 1'b0;
        end else begin
            ta_ufl_pulse_reg <= ta_uf;
            tb_ufl_pulse_reg <= tb_uf;
            if (ta_uf) timer_a_wake_request <= 1'b1;
            else if (wr_clear & wdata_reg[SBDT_CLR_TA]) timer_a_wake_request <= 1'b0;
            if (tb_uf) timer_b_wake_request <= 1'b1;
            else if (wr_clear & wdata_reg[SBDT_CLR_TB]) timer_b_wake_request <= 1'b0;
        end
    end

    // Interrupt and wake decisions; start conditions need request and wake enable with the interrupt enable clear
    logic timer_a_start_condition;
    logic timer_b_start_condition;
    assign timer_a_start_condition = timer_a_wake_request & ~enables_reg[SBDT_EN_TA_IRQ]
                                   & enables_reg[SBDT_EN_TA_WAKE];
    assign timer_b_start_condition = timer_b_wake_request & ~enables_reg[SBDT_EN_TB_IRQ]
                                   & enables_reg[SBDT_EN_TB_WAKE];
    assign irq = (timer_a_wake_request & enables_reg[SBDT_EN_TA_IRQ])
               | (timer_b_wake_request & enables_reg[SBDT_EN_TB_IRQ]);
    assign wake_up = halted & (timer_a_start_condition | timer_b_start_condition);
    assign conv_count_enable = conv_en_reg;
    assign timer_a_underflow = ta_ufl_pulse_reg;
    assign timer_b_underflow = tb_ufl_pulse_reg;

    // Read mux
    logic [31:0] rd_mux;
    logic        rd_hit;
    logic [5:0]  ar_word;
    assign ar_word = {s_axi_araddr[5:2], 2'h0};
    assign rd_hit = (ar_word == SBDT_OFS_FLAGS) | (ar_word == SBDT_OFS_ENABLES)
                  | (ar_word == SBDT_OFS_STATUS) | (ar_word == SBDT_OFS_COUNT)
                  | (ar_word == SBDT_OFS_EXTSTS) | (ar_word == SBDT_OFS_TA_LOAD)
                  | (ar_word == SBDT_OFS_TB_LOAD) | (ar_word == SBDT_OFS_CLEAR);
    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (ar_word)
            SBDT_OFS_TA_LOAD: rd_mux = {23'h0, ta_sel_reg, ta_cnt_reg};
            SBDT_OFS_TB_LOAD: rd_mux = {23'h0, tb_sel_reg, tb_cnt_reg};
            SBDT_OFS_FLAGS:   rd_mux = {24'h0, ta_reload_reg, 4'h0, conv_mode_reg,
                                        gate_extend_flag, tb_reload_reg};
            SBDT_OFS_ENABLES: rd_mux = {28'h0, enables_reg};
            SBDT_OFS_STATUS:  rd_mux = {24'h0, conv_en_reg, tb_run_reg, ta_run_reg,
                                        timer_b_start_condition, timer_a_start_condition,
                                        1'b0, timer_b_wake_request, timer_a_wake_request};
            SBDT_OFS_COUNT:   rd_mux = {20'h0, tb_cnt_reg, ta_cnt_reg};
            SBDT_OFS_EXTSTS:  rd_mux = {30'h0, timer_b_start_condition, 1'b0};
            default:          rd_mux = 32'h0000_0000;
        endcase
    end

    // AXI4-Lite read side: one cycle answer, held until rready
    logic        rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0]  rresp_reg;
    assign s_axi_arready = ~rvalid_reg;
    assign s_axi_rvalid  = rvalid_reg;
    assign s_axi_rdata   = rdata_reg;
    assign s_axi_rresp   = rresp_reg;
    always_ff @(posedge mclk) begin
        if (rst) begin
            rvalid_reg <= 1'b0;
            rdata_reg  <= '0;
            rresp_reg  <= SBDT_RESP_OKAY;
        end else if (s_axi_arvalid & ~rvalid_reg) begin
            rvalid_reg <= 1'b1;
            rdata_reg  <= rd_mux;
            rresp_reg  <= rd_hit ? SBDT_RESP_OKAY : SBDT_RESP_SLVERR;
        end else if (rvalid_reg & s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end

endmodule // sbdt_timers

// [hw/sbdt_pkg.sv]
// Package for the dual six-bit down timers: register map, fields, reset values
package sbdt_pkg;

    // Register byte offsets on the AXI4-Lite slave
    localparam logic [5:0] SBDT_OFS_TA_LOAD = 6'h00;
    localparam logic [5:0] SBDT_OFS_TB_LOAD = 6'h04;
    localparam logic [5:0] SBDT_OFS_FLAGS   = 6'h08;
    localparam logic [5:0] SBDT_OFS_ENABLES = 6'h0c;
    localparam logic [5:0] SBDT_OFS_STATUS  = 6'h10;
    localparam logic [5:0] SBDT_OFS_COUNT   = 6'h14;
    localparam logic [5:0] SBDT_OFS_CLEAR   = 6'h18;
    localparam logic [5:0] SBDT_OFS_EXTSTS  = 6'h1c;

    // Load word layout
    localparam int SBDT_LOAD_WIDTH = 9;
    localparam int SBDT_SEL_HI     = 8;
    localparam int SBDT_SEL_LO     = 6;
    localparam int SBDT_CNT_HI     = 5;
    // Load register bit 9 marks the register form (bit 8 forced to zero)
    localparam int SBDT_REG_FORM_BIT = 9;

    // Flag register bits
    localparam int SBDT_FLG_TB_RELOAD = 0;   // operand 1h
    localparam int SBDT_FLG_GATE_EXT  = 1;   // operand 2h
    localparam int SBDT_FLG_CONV_MODE = 2;
    localparam int SBDT_FLG_TA_RELOAD = 7;   // operand 80h

    // Enable register bits
    localparam int SBDT_EN_TA_IRQ  = 0;
    localparam int SBDT_EN_TA_WAKE = 1;
    localparam int SBDT_EN_TB_IRQ  = 2;
    localparam int SBDT_EN_TB_WAKE = 3;

    // Wake request clear bits
    localparam int SBDT_CLR_TA = 0;
    localparam int SBDT_CLR_TB = 1;

    // Extended wake status: timer b start condition at bit 1
    localparam int SBDT_EXT_TB_SC_BIT = 1;

    // Clock select codes and reset values
    localparam logic [2:0] SBDT_SEL_TAP9  = 3'h0;
    localparam logic [2:0] SBDT_SEL_TAP3  = 3'h1;
    localparam logic [2:0] SBDT_SEL_TAP15 = 3'h2;
    localparam logic [2:0] SBDT_SEL_EXT   = 3'h3;
    localparam logic [2:0] SBDT_SEL_TAP5  = 3'h4;
    localparam logic [2:0] SBDT_SEL_TAP7  = 3'h5;
    localparam logic [2:0] SBDT_SEL_TAP11 = 3'h6;
    localparam logic [2:0] SBDT_SEL_TAP13 = 3'h7;
    localparam logic [2:0] SBDT_TA_SEL_RST = SBDT_SEL_TAP3;
    localparam logic [2:0] SBDT_TB_SEL_RST = SBDT_SEL_TAP7;

    localparam logic [5:0] SBDT_CNT_MAX   = 6'h3f;
    localparam logic [5:0] SBDT_CNT_RST   = 6'h00;
    localparam int         SBDT_PREDIV_W  = 15;

    // AXI responses
    localparam logic [1:0] SBDT_RESP_OKAY   = 2'h0;
    localparam logic [1:0] SBDT_RESP_SLVERR = 2'h2;

endpackage

// [test/sbdt_timers_asserts.sv]
// Port-level checks for the dual six-bit down timers
`timescale 1ns/1ps
module sbdt_timers_chk
    import sbdt_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic wdt_rst,
    input wire logic halted,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic irq,
    input wire logic wake_up,
    input wire logic conv_count_enable,
    input wire logic timer_a_underflow,
    input wire logic timer_b_underflow
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);

    // Strobes are single cycles; no tap or synced edge comes faster than this
    property p_ua_pulse;
        timer_a_underflow |=> !timer_a_underflow [*4];
    endproperty
    a_ua_pulse: assert property (p_ua_pulse)
        else $error("timer a strobe too long");
    property p_ub_pulse;
        timer_b_underflow |=> !timer_b_underflow [*4];
    endproperty
    a_ub_pulse: assert property (p_ub_pulse)
        else $error("timer b strobe too long");
    // Wake only while the cpu sits in halt
    property p_wake;
        wake_up |-> halted;
    endproperty
    a_wake: assert property (p_wake)
        else $error("wake outside halt");
    // Interrupt, wake and converter gate quiet right after a power-on reset
    property p_quiet;
        $fell(rst) |-> !irq && !wake_up && !conv_count_enable;
    endproperty
    a_quiet: assert property (p_quiet)
        else $error("outputs active after reset");
    // The gate only drops with a timer b underflow or a watchdog reset
    property p_gate;
        $fell(conv_count_enable) |->
            timer_b_underflow || $past(timer_b_underflow) || $past(wdt_rst);
    endproperty
    a_gate: assert property (p_gate)
        else $error("gate dropped without underflow");
    property p_rlat;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_rlat: assert property (p_rlat)
        else $error("read answer late");
    property p_bone;
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
    endproperty
    a_bone: assert property (p_bone)
        else $error("second write response");
    property p_rone;
        s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
    endproperty
    a_rone: assert property (p_rone)
        else $error("second read response");
endmodule // sbdt_timers_chk

bind sbdt_timers sbdt_timers_chk sbdt_timers_chk_i (
    .mclk(mclk), .rst(rst), .wdt_rst(wdt_rst), .halted(halted),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .irq(irq), .wake_up(wake_up), .conv_count_enable(conv_count_enable),
    .timer_a_underflow(timer_a_underflow), .timer_b_underflow(timer_b_underflow)
);

// [test/tb_top.sv]
// Self-checking bench for the dual six-bit down timers
`timescale 1ns/1ps
module tb_top
    import sbdt_pkg::*;
;
    logic        mclk, rst, wdt_rst, ext_count_clock, halted;
    logic [5:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic        irq, wake_up, conv_count_enable, timer_a_underflow, timer_b_underflow;
    int          err_total, checked, cyc, ua, ub, ta, tb, ia, ib, gl;
    int          stg[8] = '{9, 3, 15, 0, 5, 7, 11, 13};
    logic [33:0] rq[$], bq[$];
    logic [31:0] rm[$];

    sbdt_timers sbdt_timers_i (
        .mclk(mclk), .rst(rst), .wdt_rst(wdt_rst), .ext_count_clock(ext_count_clock),
        .halted(halted), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .irq(irq), .wake_up(wake_up), .conv_count_enable(conv_count_enable),
        .timer_a_underflow(timer_a_underflow), .timer_b_underflow(timer_b_underflow)
    );

    // 50 MHz system clock
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    task automatic check(input logic [33:0] seen, input logic [33:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict();
        $display("errors=%0d checks=%0d", err_total, checked);
        if (err_total == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // Watcher: bus answers against queued notes, underflow times, gate length
    always @(posedge mclk) begin
        if (cyc % 5 == 0)
            ext_count_clock <= ~ext_count_clock; // Slow source, one rising edge per ten cycles
        if (timer_a_underflow) begin
            ua++;
            ia = cyc - ta;
            ta = cyc;
        end
        if (timer_b_underflow) begin
            ub++;
            ib = cyc - tb;
            tb = cyc;
        end
        if (conv_count_enable)
            gl++;
        if (s_axi_bvalid && s_axi_bready)
            check({s_axi_bresp, 32'h0}, bq.pop_front());
        if (s_axi_rvalid && s_axi_rready)
            check({s_axi_rresp, s_axi_rdata & rm.pop_front()}, rq.pop_front());
        cyc++;
    end

    // Write: address and data offered together, each dropped once taken
    task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [1:0] r);
        bq.push_back({r, 32'h0});
        @(posedge mclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge mclk);
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
    endtask

    task automatic rd(input logic [5:0] a, input logic [31:0] m, input logic [31:0] d,
                      input logic [1:0] r);
        rm.push_back(m);
        rq.push_back({r, d & m});
        @(posedge mclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge mclk);
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
    endtask

    // No underflow before lo cycles, exactly n of them by hi
    task automatic win(input int lo, input int hi, input bit b, input int n);
        int c0;
        c0 = b ? ub : ua;
        repeat (lo) @(posedge mclk);
        check(34'((b ? ub : ua) - c0), 34'h0);
        repeat (hi - lo) @(posedge mclk);
        check(34'((b ? ub : ua) - c0), 34'(n));
    endtask

    initial begin
        int n, s, c;
        {rst, wdt_rst, halted, ext_count_clock} = 4'h8;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
        {s_axi_awaddr, s_axi_araddr} = 12'h0;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hf;
        {err_total, checked, cyc, ua, ub, ta, tb, ia, ib, gl} = '0;
        void'($urandom(32'h6a55));
        repeat (16) @(posedge mclk);
        rst <= 1'b0;
        rd(SBDT_OFS_STATUS, 32'hff, 32'h0, SBDT_RESP_OKAY);
        rd(SBDT_OFS_COUNT, 32'hfff, 32'h0, SBDT_RESP_OKAY);
        rd(6'h20, 32'h0, 32'h0, SBDT_RESP_SLVERR);
        wr(6'h24, 32'h1, SBDT_RESP_SLVERR);
        // Timer a, random count on the fastest tap
        n = $urandom_range(62, 1);
        wr(SBDT_OFS_TA_LOAD, {23'h0, SBDT_SEL_TAP3, n[5:0]}, SBDT_RESP_OKAY);
        win(n * 8 - 2, n * 8 + 14, 0, 1);
        rd(SBDT_OFS_STATUS, 32'h21, 32'h1, SBDT_RESP_OKAY);
        rd(SBDT_OFS_COUNT, 32'h3f, 32'h3f, SBDT_RESP_OKAY);
        win(0, 600, 0, 0);
        wr(SBDT_OFS_ENABLES, 32'h1, SBDT_RESP_OKAY);
        repeat (2) @(posedge mclk);
        check({32'h0, irq, wake_up}, 34'h2);
        halted <= 1'b1;
        wr(SBDT_OFS_ENABLES, 32'h2, SBDT_RESP_OKAY);
        repeat (2) @(posedge mclk);
        check({32'h0, irq, wake_up}, 34'h1);
        rd(SBDT_OFS_STATUS, 32'h8, 32'h8, SBDT_RESP_OKAY);
        wr(SBDT_OFS_CLEAR, 32'h1, SBDT_RESP_OKAY);
        repeat (2) @(posedge mclk);
        check({32'h0, irq, wake_up}, 34'h0);
        // Timer b through every prescaler code; two ticks, one on the slowest
        for (int k = 0; k < 8; k++) begin
            if (k != 3) begin
                s = stg[k];
                c = (k == 2) ? 0 : 1;
                wr(SBDT_OFS_TB_LOAD, {23'h0, 3'(k), 6'(c)}, SBDT_RESP_OKAY);
                win(c ? (1 << s) - 2 : 0, ((c + 1) << s) + 4, 1, 1);
            end
        end
        wr(SBDT_OFS_ENABLES, 32'h4, SBDT_RESP_OKAY);
        repeat (2) @(posedge mclk);
        check({32'h0, irq, wake_up}, 34'h2);
        wr(SBDT_OFS_ENABLES, 32'h8, SBDT_RESP_OKAY);
        repeat (2) @(posedge mclk);
        check({32'h0, irq, wake_up}, 34'h1);
        rd(SBDT_OFS_EXTSTS, 32'h2, 32'h2, SBDT_RESP_OKAY);
        wr(SBDT_OFS_CLEAR, 32'h2, SBDT_RESP_OKAY);
        rd(SBDT_OFS_EXTSTS, 32'h2, 32'h0, SBDT_RESP_OKAY);
        halted <= 1'b0;
        // Register form: bit 8 forced low turns code 7 into the external source
        wr(SBDT_OFS_TB_LOAD, {22'h0, 1'b1, 3'h7, 6'h04}, SBDT_RESP_OKAY);
        win(38, 64, 1, 1);
        // Watchdog keeps the selects; re-load gives 64-tick periods
        wr(SBDT_OFS_TA_LOAD, {23'h0, SBDT_SEL_TAP5, 6'h02}, SBDT_RESP_OKAY);
        wr(SBDT_OFS_TB_LOAD, {23'h0, SBDT_SEL_TAP3, 6'h02}, SBDT_RESP_OKAY);
        wdt_rst <= 1'b1;
        @(posedge mclk);
        wdt_rst <= 1'b0;
        wr(SBDT_OFS_FLAGS, 32'h81, SBDT_RESP_OKAY);
        repeat (6000) @(posedge mclk);
        check(34'(ia), 34'd2048);
        check(34'(ib), 34'd512);
        wr(SBDT_OFS_FLAGS, 32'h0, SBDT_RESP_OKAY);
        win(0, 600, 1, 0);
        // Power-on reset restores default taps
        rst <= 1'b1;
        repeat (16) @(posedge mclk);
        rst <= 1'b0;
        wr(SBDT_OFS_FLAGS, 32'h81, SBDT_RESP_OKAY);
        repeat (8600) @(posedge mclk);
        check(34'(ia), 34'd512);
        check(34'(ib), 34'd8192);
        // Converter gate: exact length, then held across underflows
        wr(SBDT_OFS_FLAGS, 32'h4, SBDT_RESP_OKAY);
        gl = 0;
        wr(SBDT_OFS_TB_LOAD, {23'h0, SBDT_SEL_TAP3, 6'h03}, SBDT_RESP_OKAY);
        win(20, 50, 1, 1);
        check({33'h0, conv_count_enable}, 34'h0);
        check(34'(gl), 34'd32);
        wr(SBDT_OFS_FLAGS, 32'h7, SBDT_RESP_OKAY);
        wr(SBDT_OFS_TB_LOAD, {23'h0, SBDT_SEL_TAP3, 6'h01}, SBDT_RESP_OKAY);
        win(0, 560, 1, 2);
        check({33'h0, conv_count_enable}, 34'h1);
        wr(SBDT_OFS_FLAGS, 32'h5, SBDT_RESP_OKAY);
        win(0, 530, 1, 1);
        repeat (2) @(posedge mclk);
        check({33'h0, conv_count_enable}, 34'h0);
        wr(SBDT_OFS_FLAGS, 32'h4, SBDT_RESP_OKAY);
        repeat (4) @(posedge mclk);
        give_verdict();
    end

    // Hang guard, well past the expected run length
    initial begin
        #2000000;
        err_total++;
        give_verdict();
    end
endmodule // tb_top
